// ---- xcr_pkg.sv ----
// Constants shared by the oscillator calibration register bank
package xcr_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 8;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CAL_HIGH  = 8'h3D;
  localparam logic [7:0] IDX_HOLD_LOW  = 8'h3E;
  localparam logic [7:0] IDX_CAL_WORD  = 8'h38;
  localparam logic [7:0] IDX_CAL_OFS   = 8'h39;
  localparam logic [7:0] IDX_CAL_PPM   = 8'h3A;
  localparam logic [7:0] IDX_HOLD_WORD = 8'h3B;

  // ==========================================================================
  // Values after reset
  localparam logic [7:0]  RST_CAL_HIGH = 8'h99;
  localparam logic [7:0]  RST_HOLD_LOW = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [16:0] RST_OFS      = 17'h00000;
  localparam logic [28:0] RST_PPM      = 29'h0000000;
  localparam logic [31:0] RST_RDATA    = 32'h00000000;

  // ==========================================================================
  // Calibration arithmetic
  // Word value that means zero offset from the 12.800 MHz nominal crystal
  localparam logic [15:0] CAL_NOMINAL     = 16'h9999;
  // 0.0196229 ppm per LSB in Q16, i.e. round(0.0196229 * 65536)
  localparam logic [11:0] PPM_PER_LSB_Q16 = 12'h506;
  localparam int          PPM_FRAC_BITS   = 16;
  localparam int          XO_NOMINAL_KHZ  = 12800;
  localparam int          PPM_RANGE_LOW   = -771;
  localparam int          PPM_RANGE_HIGH  = 514;

endpackage : xcr_pkg

// ---- xcr_reg_if.sv ----
// Write port and stored value of one byte register
`timescale 1ns/1ps
interface xcr_reg_if;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] value;

  modport ctl
  (
    output wr_en,
    output wr_data,
    input  value
  );

  modport store
  (
    input  wr_en,
    input  wr_data,
    output value
  );
endinterface : xcr_reg_if

// ---- xcr_byte_reg.sv ----
// One read/write byte register with a reset value
`timescale 1ns/1ps
module xcr_byte_reg
#(
  parameter logic [7:0] RESET_VAL = 8'h00
)
(
  input wire logic clk,
  input wire logic rst,
  xcr_reg_if.store bus
);

  logic [7:0] value_reg;
  logic [7:0] value_next;

  assign value_next = bus.wr_en ? bus.wr_data : value_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
      value_reg <= RESET_VAL;
    else
      value_reg <= value_next;
  end

  assign bus.value = value_reg;

endmodule : xcr_byte_reg

// ---- xcr_ppm_calc.sv ----
// Converts the unsigned calibration word into a signed offset
`timescale 1ns/1ps
module xcr_ppm_calc
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic        [15:0] cal_word,
  output logic signed      [16:0] offset_lsb,
  output logic signed      [28:0] offset_ppm_q16
);

  logic signed [16:0] ofs_reg;
  logic signed [16:0] ofs_next;
  logic signed [28:0] ppm_reg;
  logic signed [28:0] ppm_next;
  logic signed [12:0] scale;

  // ==========================================================================
  // Offset arithmetic
  // word is unsigned
  assign ofs_next = $signed({1'b0, cal_word}) - $signed({1'b0, xcr_pkg::CAL_NOMINAL});
  assign scale    = $signed({1'b0, xcr_pkg::PPM_PER_LSB_Q16});
  // scale to ppm
  // Product fits 29 bits: 17-bit offset times 12-bit positive scale
  assign ppm_next = 29'(ofs_reg * scale);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ofs_reg <= xcr_pkg::RST_OFS;
      ppm_reg <= xcr_pkg::RST_PPM;
    end
    else
    begin
      ofs_reg <= ofs_next;
      ppm_reg <= ppm_next;
    end
  end

  assign offset_lsb     = ofs_reg;
  assign offset_ppm_q16 = ppm_reg;

endmodule : xcr_ppm_calc

// ---- xcr_regs.sv ----
// APB register bank for crystal calibration and manual holdover low byte
`timescale 1ns/1ps
module xcr_regs
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic        [11:0] paddr,
  input  wire logic        [31:0] pwdata,
  input  wire logic        [3:0]  pstrb,
  output logic             [31:0] prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic        [7:0]  cal_low_byte,
  input  wire logic        [7:0]  hold_high_byte,
  output logic             [15:0] cal_word,
  output logic signed      [16:0] cal_offset_lsb,
  output logic signed      [28:0] cal_offset_ppm_q16,
  output logic             [15:0] hold_word
);

  // ==========================================================================
  // Byte registers
  xcr_reg_if cal_high_if ();
  xcr_reg_if hold_low_if ();

  xcr_byte_reg
  #(
    .RESET_VAL (xcr_pkg::RST_CAL_HIGH)
  )
  u_cal_high
  (
    .clk (clk),
    .rst (rst),
    .bus (cal_high_if.store)
  );

  xcr_byte_reg
  #(
    .RESET_VAL (xcr_pkg::RST_HOLD_LOW)
  )
  u_hold_low
  (
    .clk (clk),
    .rst (rst),
    .bus (hold_low_if.store)
  );

  // ==========================================================================
  // Address decode
  logic [7:0] acc_index;
  logic       addr_aligned;
  logic       addr_in_page;
  logic       addr_ok;
  logic       hit_cal_high;
  logic       hit_hold_low;
  logic       hit_cal_word;
  logic       hit_cal_ofs;
  logic       hit_cal_ppm;
  logic       hit_hold_word;
  logic       hit_rw;
  logic       hit_ro;
  logic       hit_any;

  assign acc_index     = paddr[9:2];
  assign addr_aligned  = (paddr[1:0] == 2'h0);
  assign addr_in_page  = (paddr[11:10] == 2'h0);
  assign addr_ok       = addr_aligned && addr_in_page;
  assign hit_cal_high  = addr_ok && (acc_index == xcr_pkg::IDX_CAL_HIGH);
  assign hit_hold_low  = addr_ok && (acc_index == xcr_pkg::IDX_HOLD_LOW);
  assign hit_cal_word  = addr_ok && (acc_index == xcr_pkg::IDX_CAL_WORD);
  assign hit_cal_ofs   = addr_ok && (acc_index == xcr_pkg::IDX_CAL_OFS);
  assign hit_cal_ppm   = addr_ok && (acc_index == xcr_pkg::IDX_CAL_PPM);
  assign hit_hold_word = addr_ok && (acc_index == xcr_pkg::IDX_HOLD_WORD);
  assign hit_rw        = hit_cal_high || hit_hold_low;
  assign hit_ro        = hit_cal_word || hit_cal_ofs || hit_cal_ppm || hit_hold_word;
  assign hit_any       = hit_rw || hit_ro;

  // ==========================================================================
  // Transfer phases
  logic setup_phase;
  logic access_phase;
  logic bad_access;
  logic wr_commit;
  logic lane0_on;

  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  // Writes to read-only status words are refused so software notices them
  assign bad_access   = !hit_any || (pwrite && hit_ro);
  assign lane0_on     = pstrb[0];
  // Only byte lane 0 carries register data; other lanes are ignored
  assign wr_commit    = access_phase && pwrite && !bad_access && lane0_on;

  // Zero wait states: every access phase completes at its first edge
  assign pready = access_phase;

  // ==========================================================================
  // Register write strobes
  // write upper calibration byte
  assign cal_high_if.wr_en   = wr_commit && hit_cal_high;
  assign cal_high_if.wr_data = pwdata[7:0];
  assign hold_low_if.wr_en   = wr_commit && hit_hold_low;
  assign hold_low_if.wr_data = pwdata[7:0];

  // ==========================================================================
  // Assembled words
  logic [15:0] cal_word_reg;
  logic [15:0] cal_word_next;
  logic [15:0] hold_word_reg;
  logic [15:0] hold_word_next;

  assign cal_word_next  = {cal_high_if.value, cal_low_byte};
  assign hold_word_next = {hold_high_byte, hold_low_if.value};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // reset word means zero offset, so no offset step follows release
      cal_word_reg  <= xcr_pkg::CAL_NOMINAL;
      hold_word_reg <= xcr_pkg::RST_WORD;
    end
    else
    begin
      cal_word_reg  <= cal_word_next;
      hold_word_reg <= hold_word_next;
    end
  end

  assign cal_word  = cal_word_reg;
  assign hold_word = hold_word_reg;

  // ==========================================================================
  // Offset conversion
  // full word span gives -771..+514 ppm
  // reset word 9999h gives zero offset
  xcr_ppm_calc u_ppm_calc
  (
    .clk            (clk),
    .rst            (rst),
    .cal_word       (cal_word_reg),
    .offset_lsb     (cal_offset_lsb),
    .offset_ppm_q16 (cal_offset_ppm_q16)
  );

  // ==========================================================================
  // Read data
  logic [31:0] rd_cal_high;
  logic [31:0] rd_hold_low;
  logic [31:0] rd_cal_word;
  logic [31:0] rd_cal_ofs;
  logic [31:0] rd_cal_ppm;
  logic [31:0] rd_hold_word;
  logic [31:0] rd_mux;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pslverr_reg;
  logic        pslverr_next;

  assign rd_cal_high  = {24'h000000, cal_high_if.value};
  assign rd_hold_low  = {24'h000000, hold_low_if.value};
  assign rd_cal_word  = {16'h0000, cal_word_reg};
  // Signed status words are sign-extended so software reads them directly
  assign rd_cal_ofs   = {{15{cal_offset_lsb[16]}}, cal_offset_lsb};
  assign rd_cal_ppm   = {{3{cal_offset_ppm_q16[28]}}, cal_offset_ppm_q16};
  assign rd_hold_word = {16'h0000, hold_word_reg};

  assign rd_mux = hit_cal_high  ? rd_cal_high  :
                  hit_hold_low  ? rd_hold_low  :
                  hit_cal_word  ? rd_cal_word  :
                  hit_cal_ofs   ? rd_cal_ofs   :
                  hit_cal_ppm   ? rd_cal_ppm   :
                  hit_hold_word ? rd_hold_word :
                  xcr_pkg::RST_RDATA;

  // Captured in the setup cycle so prdata comes from a flop in the access cycle
  assign prdata_next  = (setup_phase && !pwrite) ? rd_mux :
                        access_phase ? prdata_reg : xcr_pkg::RST_RDATA;
  assign pslverr_next = setup_phase ? bad_access :
                        access_phase ? pslverr_reg : 1'b0;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_reg  <= xcr_pkg::RST_RDATA;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  // Error is only shown while the transfer completes
  assign pslverr = pslverr_reg && access_phase;

endmodule : xcr_regs

// ---- xcr_regs_assertions.sv ----
// Port-level checks for the oscillator calibration register bank
`timescale 1ns/1ps
// ==========================================================================
// Checker
module xcr_regs_assertions
(
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic        [31:0] pwdata,
  input wire logic        [11:0] paddr,
  input wire logic        [3:0]  pstrb,
  input wire logic        [7:0]  cal_low_byte,
  input wire logic        [7:0]  hold_high_byte,
  input wire logic        [15:0] cal_word,
  input wire logic signed [16:0] cal_offset_lsb,
  input wire logic signed [28:0] cal_offset_ppm_q16,
  input wire logic        [15:0] hold_word
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  wire       wr_acc = psel && penable && pwrite && pstrb[0];
  wire [7:0] wr_byte = pwdata[7:0];

  // ==========================================================================
  // Properties
  cal_reset_a:
    assert property ($fell(rst) |=> cal_word[15:8] == 8'h99)
    else $error("calibration high byte not at default");
  cal_join_a:
    assert property (!$past(rst) |-> cal_word[7:0] == $past(cal_low_byte))
    else $error("calibration low byte not joined");
  cal_write_a:
    assert property (wr_acc && paddr == 12'h0F4 |=> ##1 cal_word[15:8] == $past(wr_byte, 2))
    else $error("calibration high byte write lost");
  offset_unsigned_a:
    assert property (!$past(rst) |->
      cal_offset_lsb == $signed({1'b0, $past(cal_word)}) - 17'sh09999)
    else $error("offset not from unsigned word");
  ppm_scale_a:
    assert property (!$past(rst) |-> cal_offset_ppm_q16 == $past(cal_offset_lsb) * 29'sd1286)
    else $error("ppm scaling wrong");
  ppm_range_a:
    assert property (cal_offset_ppm_q16 >= -29'sd50593792 && cal_offset_ppm_q16 <= 29'sd33751040)
    else $error("ppm offset out of range");
  zero_offset_a:
    assert property (cal_word == 16'h9999 |=> ##1 cal_offset_ppm_q16 == 29'sd0)
    else $error("default word not zero offset");
  release_offset_a:
    assert property ($fell(rst) |=> cal_offset_lsb == 17'sd0 ##1 cal_offset_ppm_q16 == 29'sd0)
    else $error("offset not zero after reset release");
  hold_join_a:
    assert property (!$past(rst) |-> hold_word[15:8] == $past(hold_high_byte))
    else $error("holdover high byte not joined");
  hold_write_a:
    assert property (wr_acc && paddr == 12'h0F8 |=> ##1 hold_word[7:0] == $past(wr_byte, 2))
    else $error("holdover low byte write lost");
endmodule : xcr_regs_assertions

bind xcr_regs xcr_regs_assertions u_xcr_chk
(
  .clk, .rst, .psel, .penable, .pwrite, .pwdata, .paddr, .pstrb, .cal_low_byte,
  .hold_high_byte, .cal_word, .cal_offset_lsb, .cal_offset_ppm_q16, .hold_word
);

// ---- xcr_regs_tb.sv ----
// Self-checking bench for the oscillator calibration register bank
`timescale 1ns/1ps
module xcr_regs_tb;
  // ==========================================================================
  // Signals
  logic               clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        [11:0] paddr;
  logic        [31:0] pwdata;
  logic        [31:0] prdata;
  logic        [3:0]  pstrb;
  logic        [7:0]  cal_low_byte;
  logic        [7:0]  hold_high_byte;
  logic        [15:0] cal_word;
  logic signed [16:0] cal_offset_lsb;
  logic signed [28:0] cal_offset_ppm_q16;
  logic        [15:0] hold_word;
  logic        [15:0] words [3];
  int                 fails;
  int                 compares;
  int                 ofs;

  xcr_regs dut
  (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .cal_low_byte, .hold_high_byte, .cal_word, .cal_offset_lsb,
    .cal_offset_ppm_q16, .hold_word
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================================
  // Bus tasks
  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Data is only compared on reads that are not refused
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic err, input string nm);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    chk(nm, {err, d}, {pslverr, (wr || err) ? d : prdata});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : acc

  task automatic do_reset;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // Tests
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    cal_low_byte = 8'h99;
    hold_high_byte = 8'hA5;
    words = '{16'h0000, 16'h9999, 16'hFFFF};
    do_reset();
    acc(0, 12'h0F4, 32'h00000099, 4'hF, 0, "cal_high default");
    acc(0, 12'h0F8, 32'h00000000, 4'hF, 0, "hold_low default");
    acc(0, 12'h0E8, 32'h00000000, 4'hF, 0, "ppm at default");
    $display("test reset_values done");
    foreach (words[i])
    begin
      ofs = int'(words[i]) - 39321;
      cal_low_byte <= words[i][7:0];
      acc(1, 12'h0F4, {24'hABCDEF, words[i][15:8]}, 4'h1, 0, "cal_high write");
      repeat (4) @(posedge clk);
      acc(0, 12'h0E0, {16'h0000, words[i]}, 4'hF, 0, "cal_word");
      acc(0, 12'h0E4, ofs, 4'hF, 0, "offset lsb");
      acc(0, 12'h0E8, ofs * 1286, 4'hF, 0, "offset ppm");
    end
    $display("test calibration_word done");
    // Lane 0 strobe low must leave the byte alone
    acc(1, 12'h0F4, 32'h00000012, 4'hE, 0, "masked write");
    acc(1, 12'h4F4, 32'h00000012, 4'hF, 1, "page write");
    acc(1, 12'h0F5, 32'h00000012, 4'hF, 1, "unaligned write");
    acc(0, 12'h0F4, 32'h000000FF, 4'hF, 0, "cal_high kept");
    acc(1, 12'h0E0, 32'h00000001, 4'hF, 1, "read-only write");
    acc(0, 12'h100, 32'h00000000, 4'hF, 1, "unmapped read");
    acc(0, 12'h0E0, 32'h0000FFFF, 4'hF, 0, "cal_word kept");
    $display("test refusals done");
    acc(1, 12'h0F8, 32'h0000003C, 4'h1, 0, "hold_low write");
    repeat (3) @(posedge clk);
    acc(0, 12'h0F8, 32'h0000003C, 4'hF, 0, "hold_low read");
    acc(0, 12'h0EC, 32'h0000A53C, 4'hF, 0, "hold_word");
    hold_high_byte <= 8'h5A;
    repeat (3) @(posedge clk);
    acc(0, 12'h0EC, 32'h00005A3C, 4'hF, 0, "hold_word upper");
    $display("test holdover done");
    do_reset();
    acc(0, 12'h0F4, 32'h00000099, 4'hF, 0, "cal_high after reset");
    acc(0, 12'h0F8, 32'h00000000, 4'hF, 0, "hold_low after reset");
    $display("test second_reset done");
    give_verdict();
  end

  // Whole run needs about 120 cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule : xcr_regs_tb
